// ==== design/far_end_alarm_code_ctrl.sv ====
// alarm code controller: apb registers, fifo and flags
// assumes framer strobes and mode levels are on pclk
//
// What this block does
// [RL1] T3 operates only in c-bit parity mode
// [RL2] E3 receive always fed from receive framer
// [RL3] word: eight ones, zero, six payload, zero
// [RL4] all ones sent when no word active
// [RL5] validate after three identical consecutive words
// [RL6] lost after two successive bad words
// [RL7] validation pushes payload, sets detect flag
// [RL8] four-deep fifo, full drops the newcomer
// [RL9] overflow flag latched, cleared by status read
// [RL10] control bits 0-5 hold word A
// [RL11] control bits 8-13 hold word B
// [RL12] select: idle, ten A, ten A+B, continuous
// [RL13] action starts only on idle-to-active edge
// [RL14] host returns to idle, waits ten words
// [RL15] host changes payloads only while idle
// [RL16] control bit 14 enables idle interrupt
// [RL17] rising control bit 15 resets receive, flushes
// [RL18] detect flag latches, read clears, interrupts
// [RL19] idle flag after sixteen ones, gated interrupt
// [RL20] status 8-13 show oldest fifo entry
// [RL21] status 14 shows fifo empty live
// [RL22] status read pops the shown entry
// [RL23] one bit per framer opportunity strobe
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "alarm_code_consts.svh"
module far_end_alarm_code_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // framer mode levels
  input wire logic t3_mode,
  input wire logic cbit_parity_mode,
  // transmit overhead channel
  input wire logic tx_bit_req,
  output logic tx_bit,
  output logic tx_bit_valid,
  // receive overhead channel
  input wire logic rx_bit,
  input wire logic rx_bit_valid,
  // top-level mask and the resulting request
  input wire logic top_interrupt_mask,
  output logic alarm_code_irq
);
  import alarm_code_pkg::*;

  // ---------------------------------------------------------------
  // state of the register file and the receive fifo
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [15:0] ctrl; // control
    logic soft_prev; // last seen soft reset bit
    logic detect; // rx_word_detected
    logic idle; // rx_idle_seen
    logic ovf; // rx_fifo_overflow_flag
    logic ovf_armed; // overflow may latch again
    logic [3:0][5:0] mem; // fifo entries
    logic [1:0] rd_ptr; // oldest entry
    logic [1:0] wr_ptr; // next free entry
    logic [2:0] count; // entries held
    logic ack; // pready
    logic slverr; // unmapped
    logic [31:0] rdata; // read data
  } top_s;

  top_s r_r; // whole state
  top_s r_nxt; // next state

  logic active; // code word logic enabled by framing
  logic soft_pulse; // one cycle receive reset
  logic rx_push; // detector validated a word
  logic [5:0] rx_payload; // payload of that word
  logic rx_idle; // detector saw the idle run
  logic setup; // apb setup cycle
  logic done; // apb transfer completes this edge
  logic hit_ctrl; // address decodes to control
  logic hit_stat; // address decodes to status
  logic fifo_empty; // rx_fifo_empty_flag
  logic [15:0] status; // live status word

  // ---------------------------------------------------------------
  // framing mode and soft reset
  // ---------------------------------------------------------------
  // e3 always on; t3 only in c-bit parity
  assign active = !t3_mode || cbit_parity_mode; // see [RL1] [RL2]

  // a held one does not reset again
  assign soft_pulse = r_r.ctrl[`CTRL_SOFT_RST_BIT] && !r_r.soft_prev; // see [RL17]

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  assign setup = psel && !penable;
  assign done = psel && penable && r_r.ack;
  assign hit_ctrl = (paddr == `CTRL_ADDR);
  assign hit_stat = (paddr == `STAT_ADDR);

  // ---------------------------------------------------------------
  // live status word
  // ---------------------------------------------------------------
  assign fifo_empty = (r_r.count == 3'h0); // see [RL21]

  // data reads zero while empty, nothing stale
  always_comb
  begin
    status = 16'h0000;
    status[`STAT_DET_BIT] = r_r.detect;
    status[`STAT_IDLE_BIT] = r_r.idle;
    status[`STAT_FIFO_LSB +: 6] = fifo_empty ? 6'h00 : r_r.mem[r_r.rd_ptr]; // see [RL20]
    status[`STAT_EMPTY_BIT] = fifo_empty; // see [RL21]
    status[`STAT_OVF_BIT] = r_r.ovf;
  end

  // ---------------------------------------------------------------
  // next state of registers, flags and fifo
  // ---------------------------------------------------------------
  always_comb
  begin
    logic stat_read; // a status read completes now
    logic clr_det; // detect reported, may clear
    logic clr_idle; // idle reported, may clear
    logic clr_ovf; // overflow reported, may clear
    logic pop; // presented entry leaves
    logic push_ok; // new word fits
    logic drop; // new word refused
    stat_read = 1'b0;
    clr_det = 1'b0;
    clr_idle = 1'b0;
    clr_ovf = 1'b0;
    pop = 1'b0;
    push_ok = 1'b0;
    drop = 1'b0;
    r_nxt = r_r;
    r_nxt.soft_prev = r_r.ctrl[`CTRL_SOFT_RST_BIT];

    // setup: capture answer in flops
    if (setup)
    begin
      r_nxt.ack = 1'b1;
      r_nxt.slverr = !(hit_ctrl || hit_stat);
      if (hit_ctrl)
        r_nxt.rdata = {16'h0000, r_r.ctrl};
      else if (hit_stat)
        r_nxt.rdata = {16'h0000, status};
      else
        r_nxt.rdata = 32'h0000_0000;
    end
    else if (done || !psel)
    begin
      // done or abandoned
      r_nxt.ack = 1'b0;
      r_nxt.slverr = 1'b0;
    end

    // writes land at the completing edge only
    if (done && pwrite && hit_ctrl)
      r_nxt.ctrl = pwdata[15:0]; // see [RL10] [RL11] [RL12] [RL16]

    // a read clears only what it showed; later events survive
    if (done && !pwrite && hit_stat)
    begin
      stat_read = 1'b1;
      clr_det = r_r.rdata[`STAT_DET_BIT]; // see [RL18]
      clr_idle = r_r.rdata[`STAT_IDLE_BIT]; // see [RL19]
      clr_ovf = r_r.rdata[`STAT_OVF_BIT]; // see [RL9]
      pop = !r_r.rdata[`STAT_EMPTY_BIT] && !fifo_empty; // see [RL22]
    end

    // full fifo keeps entries, newcomer lost
    if (rx_push)
    begin
      if (r_r.count == `FIFO_DEPTH && !pop)
        drop = 1'b1; // see [RL8]
      else
        push_ok = 1'b1;
    end

    if (soft_pulse)
    begin
      // flush to empty
      r_nxt.rd_ptr = 2'h0; // see [RL17]
      r_nxt.wr_ptr = 2'h0;
      r_nxt.count = 3'h0;
      r_nxt.ovf_armed = 1'b1;
    end
    else
    begin
      if (push_ok)
      begin
        r_nxt.mem[r_r.wr_ptr] = rx_payload; // see [RL7]
        r_nxt.wr_ptr = r_r.wr_ptr + 2'h1;
      end
      if (pop)
      begin
        r_nxt.rd_ptr = r_r.rd_ptr + 2'h1;
        r_nxt.ovf_armed = 1'b1; // see [RL9]
      end
      r_nxt.count = r_r.count + {2'b00, push_ok} - {2'b00, pop};
    end

    // sticky flags: a set in the clearing cycle wins
    r_nxt.detect = (r_r.detect && !clr_det) || rx_push; // see [RL7] [RL18]
    r_nxt.idle = (r_r.idle && !clr_idle) || rx_idle; // see [RL19]
    r_nxt.ovf = (r_r.ovf && !clr_ovf) || (drop && r_r.ovf_armed); // see [RL9]
    if (drop && r_r.ovf_armed)
      r_nxt.ovf_armed = 1'b0;
    if (stat_read && !pop && !drop && !r_r.ovf_armed && fifo_empty)
      r_nxt.ovf_armed = 1'b1;
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      r_r <= '{ctrl: `CTRL_RESET, ovf_armed: 1'b1, default: '0};
    else
      r_r <= r_nxt;
  end

  // ---------------------------------------------------------------
  // apb answers
  // ---------------------------------------------------------------
  // no wait state: ready in the first access cycle
  assign pready = r_r.ack;
  assign pslverr = r_r.slverr && r_r.ack;
  assign prdata = r_r.rdata;

  // ---------------------------------------------------------------
  // interrupt request
  // ---------------------------------------------------------------
  // idle needs its own enable too; overflow never interrupts
  assign alarm_code_irq = top_interrupt_mask &&
    (r_r.detect || (r_r.idle && r_r.ctrl[`CTRL_IDLE_IE_BIT])); // see [RL16] [RL18] [RL19]

  // ---------------------------------------------------------------
  // transmit sequencer
  // ---------------------------------------------------------------
  // host changes payloads only while idle: no shadow
  alarm_code_tx u_tx (
    .pclk(pclk),
    .presetn(presetn),
    .active(active),
    .sel(r_r.ctrl[`CTRL_SEL_LSB +: 2]),
    .word_a(r_r.ctrl[`CTRL_A_LSB +: 6]),
    .word_b(r_r.ctrl[`CTRL_B_LSB +: 6]),
    .bit_req(tx_bit_req),
    .tx_bit(tx_bit),
    .tx_bit_valid(tx_bit_valid)
  ); // see [RL14] [RL15]

  // ---------------------------------------------------------------
  // receive detector
  // ---------------------------------------------------------------
  alarm_code_rx u_rx (
    .pclk(pclk),
    .presetn(presetn),
    .active(active),
    .soft_rst(soft_pulse),
    .rx_bit(rx_bit),
    .rx_bit_valid(rx_bit_valid),
    .word_push(rx_push),
    .word_payload(rx_payload),
    .idle_seen(rx_idle)
  );

endmodule : far_end_alarm_code_ctrl
`default_nettype wire

// ==== design/alarm_code_consts.svh ====
// alarm code controller constants
// assumes inclusion by bare name
`ifndef ALARM_CODE_CONSTS_SVH
`define ALARM_CODE_CONSTS_SVH

// printed indices; byte address is four times
`define CTRL_INDEX 12'h090
`define STAT_INDEX 12'h092
`define CTRL_ADDR 12'h240
`define STAT_ADDR 12'h248

// control fields
`define CTRL_A_LSB 0
`define CTRL_SEL_LSB 6
`define CTRL_B_LSB 8
`define CTRL_IDLE_IE_BIT 14
`define CTRL_SOFT_RST_BIT 15
`define CTRL_RESET 16'h0000

// status fields
`define STAT_DET_BIT 0
`define STAT_IDLE_BIT 1
`define STAT_FIFO_LSB 8
`define STAT_EMPTY_BIT 14
`define STAT_OVF_BIT 15

// code word shape and counts
`define WORD_HEAD 8'hff
`define WORD_LAST_BIT 4'hf
`define WORD_REPEAT_LAST 4'h9
`define CONFIRM_LAST 2'h2
`define LOSS_LAST 2'h1
`define IDLE_ONES_LAST 5'h0f
`define FIFO_DEPTH 3'h4

`endif

// ==== design/alarm_code_pkg.sv ====
// alarm code controller types
// assumes nothing of its surroundings
package alarm_code_pkg;

  // transmit action in progress
  typedef enum logic [1:0] {tx_idle, tx_send_a, tx_send_b, tx_cont_a} tx_state_e;

  // receive detector phase
  typedef enum logic [1:0] {rx_hunt, rx_confirm, rx_valid} rx_state_e;

  typedef struct packed {
    tx_state_e st;
    logic two_words;
    logic [3:0] bit_idx;
    logic [3:0] word_cnt;
    logic [1:0] sel_prev;
    logic pend;
    logic [1:0] pend_sel;
    logic tx_bit;
    logic bit_valid;
  } tx_s;

  typedef struct packed {
    rx_state_e st;
    logic [15:0] sr;
    logic [3:0] bit_cnt;
    logic [1:0] hits;
    logic [1:0] misses;
    logic [5:0] cand;
    logic after_valid;
    logic [4:0] ones;
    logic push;
    logic [5:0] payload;
    logic idle;
  } rx_s;

endpackage : alarm_code_pkg

// ==== design/alarm_code_tx.sv ====
// transmit code word sequencer, one bit per overhead opportunity
// assumes bit_req is a one-cycle strobe per opportunity
`timescale 1ns/1ps
`default_nettype none
`include "alarm_code_consts.svh"
module alarm_code_tx (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic active,
  input wire logic [1:0] sel,
  input wire logic [5:0] word_a,
  input wire logic [5:0] word_b,
  input wire logic bit_req,
  output logic tx_bit,
  output logic tx_bit_valid
);
  import alarm_code_pkg::*;

  tx_s r_r; // whole state
  tx_s r_nxt; // next state

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  always_comb
  begin
    tx_state_e st;
    logic [3:0] cnt;
    logic [15:0] word;
    st = r_r.st;
    cnt = r_r.word_cnt;
    word = '1;
    r_nxt = r_r;
    r_nxt.bit_valid = 1'b0;
    r_nxt.sel_prev = sel;
    if (!active)
    begin
      // t3 outside c-bit parity: the channel carries ones only
      r_nxt.st = tx_idle; // see [RL1]
      r_nxt.pend = 1'b0;
      r_nxt.tx_bit = 1'b1;
      // opportunities are still answered, with ones
      r_nxt.bit_valid = bit_req; // see [RL23]
    end
    else if (bit_req)
    begin
      // a pending action starts only on a word boundary
      if (r_r.st == tx_idle && r_r.pend && r_r.bit_idx == 4'h0)
      begin
        st = (r_r.pend_sel == 2'b11) ? tx_cont_a : tx_send_a; // see [RL12]
        r_nxt.two_words = (r_r.pend_sel == 2'b10);
        r_nxt.pend = 1'b0;
        cnt = 4'h0;
      end
      // payload lsb first, after ones and a zero
      word = {1'b0, (st == tx_send_b) ? word_b : word_a, 1'b0, `WORD_HEAD}; // see [RL3] [RL10] [RL11]
      r_nxt.tx_bit = (st == tx_idle) ? 1'b1 : word[r_r.bit_idx]; // see [RL4] [RL23]
      r_nxt.bit_valid = 1'b1;
      r_nxt.bit_idx = r_r.bit_idx + 4'h1;
      if (r_r.bit_idx == `WORD_LAST_BIT && st != tx_idle)
      begin
        unique case (st)
          tx_send_a:
          begin
            if (cnt == `WORD_REPEAT_LAST)
            begin
              st = r_nxt.two_words ? tx_send_b : tx_idle;
              cnt = 4'h0;
            end
            else
              cnt = cnt + 4'h1;
          end
          tx_send_b:
          begin
            if (cnt == `WORD_REPEAT_LAST)
              st = tx_idle;
            else
              cnt = cnt + 4'h1;
          end
          tx_cont_a:
          begin
            // continuous: ends on idle after ten
            if (cnt != `WORD_REPEAT_LAST)
              cnt = cnt + 4'h1;
            else if (sel == 2'b00)
              st = tx_idle;
          end
          tx_idle: ;
        endcase
      end
      r_nxt.st = st;
      r_nxt.word_cnt = cnt;
    end
    // only a move out of idle requests an action
    if (active && r_r.sel_prev == 2'b00 && sel != 2'b00)
    begin
      r_nxt.pend = 1'b1; // see [RL13]
      r_nxt.pend_sel = sel;
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      r_r <= '{st: tx_idle, tx_bit: 1'b1, default: '0};
    else
      r_r <= r_nxt;
  end

  assign tx_bit = r_r.tx_bit;
  assign tx_bit_valid = r_r.bit_valid;

endmodule : alarm_code_tx
`default_nettype wire

// ==== design/alarm_code_rx.sv ====
// receive code word detector: hunt, confirm, lose
// assumes one bit per rx_bit_valid pulse, on pclk
`timescale 1ns/1ps
`default_nettype none
`include "alarm_code_consts.svh"
module alarm_code_rx (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic active,
  input wire logic soft_rst,
  input wire logic rx_bit,
  input wire logic rx_bit_valid,
  output logic word_push,
  output logic [5:0] word_payload,
  output logic idle_seen
);
  import alarm_code_pkg::*;

  rx_s r_r; // whole state
  rx_s r_nxt; // next state

  // ---------------------------------------------------------------
  // detector
  // ---------------------------------------------------------------
  always_comb
  begin
    logic [15:0] sr;
    logic match;
    logic [5:0] pay;
    sr = {rx_bit, r_r.sr[15:1]};
    match = (sr[7:0] == `WORD_HEAD) && !sr[8] && !sr[15];
    pay = sr[14:9];
    r_nxt = r_r;
    r_nxt.push = 1'b0;
    r_nxt.idle = 1'b0;
    if (soft_rst || !active)
      r_nxt = '0; // see [RL17] [RL1]
    else if (rx_bit_valid)
    begin
      r_nxt.sr = sr; // see [RL2]
      r_nxt.bit_cnt = r_r.bit_cnt + 4'h1;
      // sixteen ones after a valid word: idle
      r_nxt.ones = rx_bit ? ((r_r.ones == `IDLE_ONES_LAST) ? r_r.ones : r_r.ones + 5'h1) : 5'h0;
      if (rx_bit && r_r.after_valid && r_r.ones == `IDLE_ONES_LAST)
      begin
        r_nxt.idle = 1'b1; // see [RL19]
        r_nxt.after_valid = 1'b0;
      end
      unique case (r_r.st)
        rx_hunt:
        begin
          // bit by bit search for the word shape
          if (match)
          begin
            r_nxt.st = rx_confirm; // see [RL5]
            r_nxt.cand = pay;
            r_nxt.hits = 2'h1;
            r_nxt.bit_cnt = 4'h0;
          end
        end
        rx_confirm:
        begin
          if (r_r.bit_cnt == `WORD_LAST_BIT)
          begin
            if (match && pay == r_r.cand && r_r.hits == `CONFIRM_LAST)
            begin
              r_nxt.st = rx_valid; // see [RL5] [RL7]
              r_nxt.push = 1'b1;
              r_nxt.payload = r_r.cand;
              r_nxt.after_valid = 1'b1;
              r_nxt.misses = 2'h0;
            end
            else if (match && pay == r_r.cand)
              r_nxt.hits = r_r.hits + 2'h1;
            else if (match)
            begin
              // a different word restarts confirmation
              r_nxt.cand = pay;
              r_nxt.hits = 2'h1;
            end
            else
              r_nxt.st = rx_hunt;
          end
        end
        rx_valid:
        begin
          if (r_r.bit_cnt == `WORD_LAST_BIT)
          begin
            if (match && pay == r_r.cand)
              r_nxt.misses = 2'h0;
            else if (r_r.misses == `LOSS_LAST)
            begin
              r_nxt.st = rx_hunt; // see [RL6]
              r_nxt.misses = 2'h0;
            end
            else
              r_nxt.misses = r_r.misses + 2'h1;
          end
        end
        default: r_nxt.st = rx_hunt;
      endcase
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      r_r <= '0;
    else
      r_r <= r_nxt;
  end

  assign word_push = r_r.push;
  assign word_payload = r_r.payload;
  assign idle_seen = r_r.idle;

endmodule : alarm_code_rx
`default_nettype wire

// ==== tb/far_end_alarm_code_ctrl_asserts.sv ====
// alarm code controller checker: bus, strobes, fields, mask
// assumes a bind to the top module
`timescale 1ns/1ps
`default_nettype none
`include "alarm_code_consts.svh"
module alarm_code_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic t3_mode,
  input wire logic cbit_parity_mode,
  input wire logic tx_bit_req,
  input wire logic tx_bit,
  input wire logic tx_bit_valid,
  input wire logic top_interrupt_mask,
  input wire logic alarm_code_irq
);
  // ------------------------------------------
  // one domain, reset silences every property
  // ------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // t3 without c-bit parity: ones only
  logic quiet;
  assign quiet = t3_mode && !cbit_parity_mode;

  // ------------------------------------------
  // properties
  // ------------------------------------------
  a_access_ready: assert property (psel && !penable |=> pready)
    else $error("no ready in the access cycle");
  a_ready_single: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_unmapped_err: assert property (pready |->
      pslverr == !(paddr == `CTRL_ADDR || paddr == `STAT_ADDR))
    else $error("wrong error response");
  a_upper_zero: assert property (pready && !pwrite |-> prdata[31:16] == 0)
    else $error("upper read bits not zero");
  a_status_fields: assert property (pready && !pwrite &&
      paddr == `STAT_ADDR |->
      prdata[7:2] == 6'h0 && (!prdata[14] || prdata[13:8] == 6'h0))
    else $error("status zero bits set");
  a_bit_strobe: assert property (tx_bit_valid == $past(tx_bit_req))
    else $error("strobe not one cycle after request");
  a_bit_holds: assert property (!tx_bit_req |=> $stable(tx_bit))
    else $error("bit moved without request");
  a_quiet_ones: assert property (tx_bit_valid && quiet &&
      $past(quiet) |-> tx_bit)
    else $error("zero sent while inactive");
  a_irq_masked: assert property (!top_interrupt_mask |->
      !alarm_code_irq)
    else $error("interrupt raised while masked");

  // main scenarios reached
  c_unmapped: cover property (pready && pslverr);
  c_entry: cover property (pready && paddr == `STAT_ADDR && !prdata[14]);
  c_irq: cover property (alarm_code_irq);
  c_zero_sent: cover property (tx_bit_valid && !tx_bit);
endmodule : alarm_code_checker
`default_nettype wire

// ==== tb/framer_model.sv ====
// framer side: a bit slot every four cycles, collects tx bits,
// plays a receive pattern
`timescale 1ns/1ps
`default_nettype none
module framer_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [15:0] rx_pat,
  input wire logic tx_bit,
  input wire logic tx_bit_valid,
  output logic tx_bit_req,
  output logic rx_bit,
  output logic rx_bit_valid,
  output logic [15:0] tx_win
);
  logic [1:0] ph; // slot phase
  logic [3:0] idx; // receive bit index, lsb of pattern first

  // slot strobes; receive line shows the inverse once its bit is gone
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ph <= 2'h0;
      idx <= 4'h0;
      tx_bit_req <= 1'b0;
      rx_bit_valid <= 1'b0;
      rx_bit <= 1'b1;
      tx_win <= 16'hffff;
    end
    else
    begin
      ph <= ph + 2'h1;
      tx_bit_req <= (ph == 2'h3);
      rx_bit_valid <= (ph == 2'h3);
      if (ph == 2'h3)
      begin
        rx_bit <= rx_pat[idx];
        idx <= idx + 4'h1;
      end
      else if (rx_bit_valid)
        rx_bit <= ~rx_bit;
      // newest bit on top: aligned word reads as written
      if (tx_bit_valid)
        tx_win <= {tx_bit, tx_win[15:1]};
    end
  end
endmodule : framer_model
`default_nettype wire

// ==== tb/far_end_alarm_code_ctrl_tb.sv ====
// bench of the alarm code controller with a framer model
// assumes design and checker compiled first
`timescale 1ns/1ps
`default_nettype none
`include "alarm_code_consts.svh"
module far_end_alarm_code_ctrl_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic t3_mode, cbit_parity_mode, tx_bit_req, tx_bit, tx_bit_valid;
  logic rx_bit, rx_bit_valid, top_interrupt_mask, alarm_code_irq, rerr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdata, ctrl, seed;
  logic [15:0] rx_pat, tx_win;
  logic [5:0] a, b;
  logic [5:0] w [5];
  int n_mismatch, checked, cyc, cnt_a, cnt_b, s, i;

  far_end_alarm_code_ctrl dut_u (.pclk(pclk), .presetn(presetn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .t3_mode(t3_mode), .cbit_parity_mode(cbit_parity_mode),
    .tx_bit_req(tx_bit_req), .tx_bit(tx_bit), .tx_bit_valid(tx_bit_valid),
    .rx_bit(rx_bit), .rx_bit_valid(rx_bit_valid),
    .top_interrupt_mask(top_interrupt_mask),
    .alarm_code_irq(alarm_code_irq));
  framer_model fm_u (.pclk(pclk), .presetn(presetn), .rx_pat(rx_pat),
    .tx_bit(tx_bit), .tx_bit_valid(tx_bit_valid), .tx_bit_req(tx_bit_req),
    .rx_bit(rx_bit), .rx_bit_valid(rx_bit_valid), .tx_win(tx_win));

  // ------------------------------------------
  // helpers
  // ------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction : xs

  // full word as it appears on the line, lsb first
  function automatic logic [15:0] word_of(input logic [5:0] p);
    return {1'b0, p, 1'b0, 8'hff};
  endfunction : word_of

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wrap_up;
    if (n_mismatch == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : wrap_up

  // one apb transfer from just after an edge, held until ready
  task automatic apb(input logic wr, input logic [11:0] ad,
                     input logic [31:0] wd);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && ++n < 40);
    rdata = prdata;
    rerr = pslverr;
    if (n >= 40)
      check(32'h1, 32'h0);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  // ------------------------------------------
  // clock, window counters and hang guard
  // ------------------------------------------
  initial
  begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  always @(posedge pclk)
  begin
    cyc++;
    if (tx_bit_valid === 1'b1 && {tx_bit, tx_win[15:1]} == word_of(a))
      cnt_a++;
    if (tx_bit_valid === 1'b1 && {tx_bit, tx_win[15:1]} == word_of(b))
      cnt_b++;
    if (cyc == 30000)
    begin
      n_mismatch++;
      wrap_up();
    end
  end

  // ------------------------------------------
  // main sequence
  // ------------------------------------------
  initial
  begin
    {presetn, psel, penable, pwrite, t3_mode, cbit_parity_mode} = '0;
    {top_interrupt_mask, paddr, pwdata} = '0;
    rx_pat = 16'hffff;
    seed = 32'h5662;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    // reset values and an unmapped place
    apb(1'b0, `CTRL_ADDR, 32'h0);
    check(rdata, 32'h0);
    apb(1'b0, `STAT_ADDR, 32'h0);
    check(rdata, 32'h4000);
    apb(1'b1, 12'h244, 32'hffff);
    check(rerr, 1);
    // payloads loaded while idle, b always differs from a
    seed = xs(seed);
    a = seed[5:0];
    b = a ^ (seed[13:8] | 6'h01);
    ctrl = {16'h0, 2'b00, b, 2'b00, a};
    apb(1'b1, `CTRL_ADDR, ctrl);
    apb(1'b0, `CTRL_ADDR, 32'h0);
    check(rdata, ctrl);
    // every select action; t3 c-bit parity and e3 alternate
    for (s = 1; s < 4; s++)
    begin
      t3_mode <= s[0];
      cbit_parity_mode <= 1'b1;
      cnt_a = 0;
      cnt_b = 0;
      apb(1'b1, `CTRL_ADDR, ctrl | {24'h0, s[1:0], 6'h0});
      repeat (1600) @(posedge pclk);
      // rewriting the same level restarts nothing
      apb(1'b1, `CTRL_ADDR, ctrl | {24'h0, s[1:0], 6'h0});
      repeat (200) @(posedge pclk);
      apb(1'b1, `CTRL_ADDR, ctrl);
      repeat (800) @(posedge pclk);
      check(s == 3 ? cnt_a > 20 : cnt_a, s == 3 ? 1 : 10);
      check(cnt_b, s == 2 ? 10 : 0);
      check(tx_win, 32'hffff);
    end
    // t3 without c-bit parity: ones only
    t3_mode <= 1'b1;
    cbit_parity_mode <= 1'b0;
    cnt_a = 0;
    apb(1'b1, `CTRL_ADDR, ctrl | 32'h40);
    repeat (900) @(posedge pclk);
    check(cnt_a, 0);
    apb(1'b1, `CTRL_ADDR, ctrl);
    // five distinct words into a four-deep fifo, e3 receive
    t3_mode <= 1'b0;
    top_interrupt_mask <= 1'b1;
    for (i = 0; i < 5; i++)
    begin
      seed = xs(seed);
      w[i] = {seed[5:3], i[2:0]};
      rx_pat <= word_of(w[i]);
      repeat (384) @(posedge pclk);
      rx_pat <= 16'hffff;
      repeat (256) @(posedge pclk);
    end
    check(alarm_code_irq, 1);
    apb(1'b0, `STAT_ADDR, 32'h0);
    check(rdata, {16'h0, 2'b10, w[0], 8'h03});
    check(alarm_code_irq, 0);
    apb(1'b0, `STAT_ADDR, 32'h0);
    check(rdata, {16'h0, 2'b00, w[1], 8'h00});
    // soft reset flushes the rest
    apb(1'b1, `CTRL_ADDR, 32'h8000);
    apb(1'b1, `CTRL_ADDR, 32'h4000);
    apb(1'b0, `STAT_ADDR, 32'h0);
    check(rdata, 32'h4000);
    // idle flag and its gated interrupt
    rx_pat <= word_of(w[2]);
    repeat (384) @(posedge pclk);
    apb(1'b0, `STAT_ADDR, 32'h0);
    check(rdata, {16'h0, 2'b00, w[2], 8'h01});
    rx_pat <= 16'hffff;
    repeat (256) @(posedge pclk);
    check(alarm_code_irq, 1);
    top_interrupt_mask <= 1'b0;
    repeat (2) @(posedge pclk);
    check(alarm_code_irq, 0);
    apb(1'b0, `STAT_ADDR, 32'h0);
    check(rdata, 32'h4002);
    wrap_up();
  end
endmodule : far_end_alarm_code_ctrl_tb

bind far_end_alarm_code_ctrl alarm_code_checker chk_u (.pclk(pclk),
  .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .t3_mode(t3_mode), .cbit_parity_mode(cbit_parity_mode),
  .tx_bit_req(tx_bit_req), .tx_bit(tx_bit), .tx_bit_valid(tx_bit_valid),
  .top_interrupt_mask(top_interrupt_mask),
  .alarm_code_irq(alarm_code_irq));
`default_nettype wire
